// *** rtl/eph_consts.vh ***
// Constants for the peripheral-side parallel port handshake engine.
`ifndef EPH_CONSTS_VH
`define EPH_CONSTS_VH
// Core clock period in ns.
`define EPH_CLK_NS 10
// Least latch-to-wait delay: 6 core periods.
`define EPH_WAIT_MIN_SCLK 6
// Longest strobe-release to wait-release: 5 core periods.
`define EPH_REL_MAX_SCLK 5
// Least strobe to read data drive: 3 core periods.
`define EPH_RD_DRIVE_MIN_SCLK 3
// Longest read latency in bus clock periods.
`define EPH_RD_MAX_BCLK 13
// Data drive to wait assert in a read: 3 to 4 core periods.
`define EPH_RD_WAIT_SCLK 3
// Bus clock divider: bus clock at half the core clock.
`define EPH_BCLK_DIV 2
`endif

// *** rtl/eph_strobe_sync.v ***
// Two-stage synchroniser with level output for one host strobe.
`timescale 1ns/1ns
`default_nettype none
module eph_strobe_sync (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Raw active-low strobe
  input wire strobeInN,
  // Synchronised active-high level
  output reg level_r
);
  reg stage1_r;
  always @(posedge clk) begin
    if (rst) begin
      stage1_r <= 1'b0;
      level_r <= 1'b0;
    end else begin
      stage1_r <= ~strobeInN;
      level_r <= stage1_r;
    end
  end
endmodule // eph_strobe_sync
`default_nettype wire

// *** rtl/eph_epp_handshake.v ***
// Peripheral-side handshake engine for parallel port address/data cycles.
// Summary of operation
// - Latch address, then wait after six cycles.
// - Release wait within five cycles after strobe.
// - Latch data byte, then wait after six.
// - Drive read byte within allowed latency window.
// - Assert wait three cycles after drive.
// - Release bus within five cycles.
// - Drop wait within one cycle after release.
// - Initialize line never leaves this mode.
// - Acknowledge line never pulses for interrupts.
// - Read latency assumes bus clock half core.
`timescale 1ns/1ns
`default_nettype none
`include "eph_consts.vh"
module eph_epp_handshake #(
  parameter WAIT_CYC = `EPH_WAIT_MIN_SCLK,
  parameter RD_WAIT_CYC = `EPH_RD_WAIT_SCLK,
  parameter BCLK_DIV = `EPH_BCLK_DIV,
  parameter RD_MAX_BCLK = `EPH_RD_MAX_BCLK
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Host pins, strobes active low
  input wire hostWriteStrobeN,
  input wire hostAddressStrobeN,
  input wire hostDataStrobeN,
  input wire hostInitializeLineN,
  input wire [7:0] hostParallelBusIn,
  output reg [7:0] hostParallelBusOut,
  output reg hostParallelBusOeN,
  output reg peripheralWaitAck,
  output reg peripheralAckLineN,
  // Local side
  output reg [7:0] addrByte_r,
  output reg [7:0] wrByte_r,
  output reg wrValid_r,
  output reg rdReq_r,
  input wire [7:0] rdByte,
  input wire rdValid
);
  // ****************************************
  // Strobe synchronisers
  // ****************************************
  // Bit 0 is the address strobe, bit 1 the data strobe, bit 2 the write
  // strobe. All three pass the same two stages, so their relative timing
  // at the pins is kept when the state machine sees them.
  wire [2:0] strbN;
  wire [2:0] strbLvl;
  wire addrStb;
  wire dataStb;
  wire writeStb;
  assign strbN = {hostWriteStrobeN, hostDataStrobeN, hostAddressStrobeN};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : gSync
      eph_strobe_sync uSync (
        .clk(clk),
        .rst(rst),
        .strobeInN(strbN[gi]),
        .level_r(strbLvl[gi])
      );
    end
  endgenerate
  assign addrStb = strbLvl[0];
  assign dataStb = strbLvl[1];
  assign writeStb = strbLvl[2];

  // ****************************************
  // Bus clock enable divider
  // ****************************************
  // Read timeout is counted in bus clock enables, so a slower divider
  // stretches read latency exactly as the bus would.
  reg [3:0] divCnt_r;
  wire bclkEn = (divCnt_r == BCLK_DIV - 1);
  always @(posedge clk) begin
    if (rst) begin
      divCnt_r <= 4'h0;
    end else if (bclkEn) begin
      divCnt_r <= 4'h0;
    end else begin
      divCnt_r <= divCnt_r + 4'h1;
    end
  end

  // ****************************************
  // Handshake state machine
  // ****************************************
  localparam IDLE = 3'h0;
  localparam WDLY = 3'h1;
  localparam WHLD = 3'h2;
  localparam RWT = 3'h3;
  localparam RDRV = 3'h4;
  localparam RHLD = 3'h5;
  localparam RREL = 3'h6;
  // The strobe reaches the state machine three clocks late, about one and
  // a half bus clocks, so the timeout is cut by two bus clocks to keep the
  // drive inside the read window measured at the pin.
  localparam RD_TMO = RD_MAX_BCLK - 2;
  reg [2:0] state_r;
  reg [3:0] cnt_r;
  reg [4:0] bcnt_r;
  reg isAddr_r;

  // ****************************************
  // Cycle decode
  // ****************************************
  // A data cycle is a write only while the write strobe is low with it.
  wire wrCyc = dataStb && writeStb;
  wire rdCyc = dataStb && !writeStb;
  wire cycEnd = isAddr_r ? !addrStb : !dataStb;

  // ****************************************
  // Read timeout counter
  // ****************************************
  // Counts bus clock enables while a read waits for local data. It clears
  // outside the wait state and saturates, so it never wraps to zero.
  always @(posedge clk) begin
    if (rst) begin
      bcnt_r <= 5'h00;
    end else if (state_r != RWT) begin
      bcnt_r <= 5'h00;
    end else if (bclkEn && bcnt_r != 5'h1f) begin
      bcnt_r <= bcnt_r + 5'h01;
    end
  end

  // ****************************************
  // Handshake sequencing
  // ****************************************
  always @(posedge clk) begin
    if (rst) begin
      state_r <= IDLE;
      cnt_r <= 4'h0;
      isAddr_r <= 1'b0;
      addrByte_r <= 8'h00;
      wrByte_r <= 8'h00;
      wrValid_r <= 1'b0;
      rdReq_r <= 1'b0;
      hostParallelBusOut <= 8'h00;
      hostParallelBusOeN <= 1'b1;
      peripheralWaitAck <= 1'b0;
      peripheralAckLineN <= 1'b1;
    end else begin
      wrValid_r <= 1'b0;
      rdReq_r <= 1'b0;
      peripheralAckLineN <= 1'b1;
      // The initialize line is deliberately not watched here.
      case (state_r)
        IDLE: begin
          cnt_r <= 4'h1;
          if (addrStb) begin
            addrByte_r <= hostParallelBusIn;
            isAddr_r <= 1'b1;
            state_r <= WDLY;
          end else if (wrCyc) begin
            wrByte_r <= hostParallelBusIn;
            isAddr_r <= 1'b0;
            state_r <= WDLY;
          end else if (rdCyc) begin
            rdReq_r <= 1'b1;
            state_r <= RWT;
          end
        end
        WDLY: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r >= WAIT_CYC) begin
            peripheralWaitAck <= 1'b1;
            wrValid_r <= ~isAddr_r;
            state_r <= WHLD;
          end
        end
        WHLD: begin
          if (cycEnd) begin
            peripheralWaitAck <= 1'b0;
            state_r <= IDLE;
          end
        end
        RWT: begin
          // Saturate so a slow read cannot wrap the drive delay count.
          if (cnt_r != 4'hf) cnt_r <= cnt_r + 4'h1;
          if (!dataStb) begin
            state_r <= IDLE;
          end else if (cnt_r >= `EPH_RD_DRIVE_MIN_SCLK &&
                       (rdValid || bcnt_r >= RD_TMO)) begin
            hostParallelBusOut <= rdByte;
            hostParallelBusOeN <= 1'b0;
            cnt_r <= 4'h1;
            state_r <= RDRV;
          end
        end
        RDRV: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r >= RD_WAIT_CYC) begin
            peripheralWaitAck <= 1'b1;
            state_r <= RHLD;
          end
        end
        RHLD: begin
          if (!dataStb) begin
            hostParallelBusOeN <= 1'b1;
            state_r <= RREL;
          end
        end
        RREL: begin
          peripheralWaitAck <= 1'b0;
          state_r <= IDLE;
        end
        default: state_r <= IDLE;
      endcase
    end
  end
endmodule // eph_epp_handshake
`default_nettype wire

// *** test/eph_epp_handshake_assertions.sv ***
// Assertion checker for the parallel port handshake engine.
`timescale 1ns/1ns
`default_nettype none
module eph_hs_chk (
  input wire logic clk, rst,
  hostWriteStrobeN, hostAddressStrobeN, hostDataStrobeN,
  hostParallelBusOeN, peripheralWaitAck, peripheralAckLineN
);
  wire w = peripheralWaitAck;
  wire oe = !hostParallelBusOeN;
  wire aN = hostAddressStrobeN;
  wire dN = hostDataStrobeN;
  wire rd = hostWriteStrobeN;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Windows are wide enough to absorb the strobe synchroniser delay.
  a_addr_wait_late: assert property ($fell(aN) |-> !w [*6])
    else $error("wait early");
  a_data_wait_late: assert property ($fell(dN) && !rd |-> !w [*6])
    else $error("wait early");
  a_addr_wait_drop: assert property ($rose(aN) && w |-> ##[1:5] !w)
    else $error("wait stuck");
  a_read_bus_free: assert property ($rose(dN) && oe |-> ##[1:5] !oe)
    else $error("bus held");
  a_read_wait_drop: assert property ($rose(hostParallelBusOeN) |-> ##[0:1] !w)
    else $error("wait held");
  a_read_wait_rise: assert property ($fell(hostParallelBusOeN) |->
    !w [*3] ##[1:2] w)
    else $error("wait timing");
  a_drive_not_early: assert property ($fell(dN) && rd |-> !oe [*3])
    else $error("drive early");
  a_drive_not_late: assert property ($fell(dN) && rd |-> ##[3:26] oe)
    else $error("drive late");
  a_ack_stays_high: assert property (peripheralAckLineN)
    else $error("ack pulsed");
  cover property ($rose(w) && oe);
  cover property ($rose(w) && !aN);
  cover property ($rose(w) && !dN && !rd);
endmodule // eph_hs_chk
bind eph_epp_handshake eph_hs_chk chk (.clk, .rst, .hostWriteStrobeN,
  .hostAddressStrobeN, .hostDataStrobeN, .hostParallelBusOeN,
  .peripheralWaitAck, .peripheralAckLineN);
`default_nettype wire

// *** test/eph_host_model.sv ***
// Host port model driving the strobes and the shared byte lines.
`timescale 1ns/1ns
`default_nettype none
module eph_host_model (
  input wire logic clk, oeN, w,
  input wire logic [7:0] busOut,
  output logic wrN, aN, dN,
  output wire logic [7:0] busIn
);
  logic drv = 1'h0;
  logic [7:0] val = 8'h00, last = 8'h00;
  // A released bus toggles, so the stale byte shows on it only on every second clock.
  assign busIn = !oeN ? busOut : drv ? val : ~last;
  always @(posedge clk) last <= busIn;
  initial {wrN, aN, dN} = 3'h7;
  task automatic cyc(input logic a, wr, input logic [7:0] d,
                     output logic [7:0] r);
    int n;
    r = 8'hxx;
    @(posedge clk);
    wrN <= !wr;
    drv <= wr;
    val <= d;
    aN <= !a;
    dN <= a;
    for (n = 0; n < 60 && !w; n++) @(posedge clk);
    if (w) r = busIn;
    @(posedge clk);
    {aN, dN} <= 2'h3;
    for (n = 0; n < 9 && w; n++) @(posedge clk);
    if (w) r = 8'hxx;
    drv <= 1'h0;
  endtask
endmodule // eph_host_model
`default_nettype wire

// *** test/eph_epp_handshake_tb.sv ***
// Self-checking bench for the parallel port handshake engine.
`timescale 1ns/1ns
`default_nettype none
module eph_epp_handshake_tb;
  logic clk = 0, rst = 1, initN = 1, rdValid = 0;
  logic [7:0] rdByte = 8'h00, r;
  wire [7:0] busIn, busOut, addrB, wrB;
  wire oeN, w, ackN, wrN, aN, dN, wrV, rdQ;
  int num_errors = 0, total_checks = 0, cyc = 0, nWr = 0, nRd = 0;
  always #5 clk = ~clk;
  eph_epp_handshake uut (.clk, .rst, .hostWriteStrobeN(wrN),
    .hostAddressStrobeN(aN), .hostDataStrobeN(dN), .hostInitializeLineN(initN),
    .hostParallelBusIn(busIn), .hostParallelBusOut(busOut),
    .hostParallelBusOeN(oeN), .peripheralWaitAck(w), .peripheralAckLineN(ackN),
    .addrByte_r(addrB), .wrByte_r(wrB), .wrValid_r(wrV), .rdReq_r(rdQ),
    .rdByte, .rdValid);
  eph_host_model host (.clk, .oeN, .w, .busOut, .wrN, .aN, .dN, .busIn);
  task chk(input logic [7:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (wrV === 1'b1) nWr++;
    if (rdQ === 1'b1) nRd++;
    if (cyc == 3000) begin
      num_errors++;
      test_done;
    end
  end
  task t_addr;
    host.cyc(1, 1, 8'ha5, r);
    chk(addrB, 8'ha5);
    host.cyc(1, 1, 8'h5a, r);
    chk(addrB, 8'h5a);
    chk(nWr[7:0], 8'h00);
  endtask
  task t_write;
    host.cyc(0, 1, 8'h3c, r);
    chk(wrB, 8'h3c);
    chk(addrB, 8'h5a);
    chk(nWr[7:0], 8'h01);
  endtask
  task t_read(input logic v, input logic [7:0] d);
    int n0;
    n0 = nRd;
    rdValid <= v;
    rdByte <= d;
    host.cyc(0, 0, 8'h00, r);
    chk(r, d);
    chk({6'h0, oeN, w}, 8'h02);
    chk(nRd[7:0] - n0[7:0], 8'h01);
  endtask
  task t_init;
    initN <= 0;
    host.cyc(0, 1, 8'hc7, r);
    chk(wrB, 8'hc7);
    chk({7'h0, ackN}, 8'h01);
    chk(nWr[7:0], 8'h02);
    initN <= 1;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    t_addr;
    t_write;
    t_read(1, 8'hc3);
    t_read(0, 8'h96);
    t_init;
    test_done;
  end
endmodule // eph_epp_handshake_tb
`default_nettype wire
